// ==== dv/dipc_checker.sv ====
// Assertion checker for the conditioner top
`timescale 1ns/1ps
module dipc_checker #(
  parameter int unsigned NUM_INPUTS = 4,
  parameter int unsigned CYCLES_PER_MS = dipc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [dipc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Inputs and results
  input wire logic [NUM_INPUTS-1:0] din_in,
  input wire logic [NUM_INPUTS-1:0] closed_out,
  input wire logic [NUM_INPUTS-1:0] change_strobe_out,
  input wire logic [NUM_INPUTS-1:0] event_strobe_out,
  input wire logic irq_out
);
  logic [NUM_INPUTS-1:0] din_q;
  logic [NUM_INPUTS-1:0] short_v;
  logic [15:0] held_q [NUM_INPUTS];
  // Cycles since each raw line moved, saturating
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      din_q <= '0;
      for (int i = 0; i < NUM_INPUTS; i++) held_q[i] <= 16'h0;
    end else begin
      din_q <= din_in;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        held_q[i] <= (din_in[i] != din_q[i]) ? 16'h0 : held_q[i] + {15'h0, ~&held_q[i]};
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) short_v[i] = held_q[i] < CYCLES_PER_MS;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  AST_EVT_ONE: assert property (|event_strobe_out |=>
    (event_strobe_out & $past(event_strobe_out)) == '0) else $error("event strobe too long");
  AST_CHG_ONE: assert property (|change_strobe_out |=>
    (change_strobe_out & $past(change_strobe_out)) == '0) else $error("change strobe too long");
  AST_EVT_WITH_CHG: assert property ((event_strobe_out & ~change_strobe_out) == '0)
    else $error("event without change");
  AST_CHG_HELD: assert property ((change_strobe_out & short_v) == '0)
    else $error("change before debounce time");
  AST_APB_WAIT: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready late");
  AST_RDY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held");
  AST_ERR_RDY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_RDY_ACC: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access");
endmodule
bind dipc_top dipc_checker #(.NUM_INPUTS(NUM_INPUTS), .CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .din_in(din_in),
  .closed_out(closed_out), .change_strobe_out(change_strobe_out),
  .event_strobe_out(event_strobe_out), .irq_out(irq_out));

// ==== dv/dipc_contacts.sv ====
// Contact model with optional bounce bursts
`timescale 1ns/1ps
module dipc_contacts #(
  parameter int N = 4
) (
  // Clock and command
  input wire logic clk_in,
  input wire logic [N-1:0] target_in,
  input wire logic bounce_in,
  // Contact lines
  output logic [N-1:0] din_out
);
  logic [N-1:0] goal_q = '0;
  logic [N-1:0] prev_q = '0;
  logic [3:0] cnt_q = 4'h0;
  // Two-cycle bursts, far below the shortest debounce
  always @(posedge clk_in) begin
    if (target_in != goal_q) begin
      prev_q <= goal_q;
      goal_q <= target_in;
      cnt_q <= bounce_in ? 4'h9 : 4'h0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign din_out = cnt_q[1] ? prev_q : goal_q;
endmodule

// ==== dv/tb_digital_input_pulse_conditioner.sv ====
// Self-checking bench for the input conditioner
`timescale 1ns/1ps
module tb_digital_input_pulse_conditioner;
  localparam logic [3:0] MODE_V = 4'hC;
  localparam logic [3:0] SENSE_V = 4'h6;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic bounce = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] target = 4'h0;
  logic [3:0] lvl = 4'h0;
  logic [3:0] pol = 4'h0;
  logic [3:0] closed;
  logic [3:0] evt_acc = 4'h0;
  logic [3:0] chg_acc = 4'h0;
  logic [7:0] seed = 8'h46;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [3:0] din, chg, evt;
  logic [32:0] rd_q[$];
  logic [7:0] ev_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  always #12.5 mclk_in = ~mclk_in;
  dipc_contacts #(.N(4)) u_contacts (.clk_in(mclk_in), .target_in(target),
    .bounce_in(bounce), .din_out(din));
  dipc_top #(.NUM_INPUTS(4), .CYCLES_PER_MS(10)) uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .din_in(din), .closed_out(closed), .change_strobe_out(chg), .event_strobe_out(evt),
    .irq_out(irq));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] chanw(input int i, input logic [6:0] d);
    return {17'h0, d, 5'h0, SENSE_V[i], MODE_V[i], 1'b0};
  endfunction
  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic fail_wait(input string what);
    $display("BAD %s exp done got timeout", what);
    n_errors++;
    wrap_up();
  endtask
  task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) $display("BAD read exp %h got %h", e, g);
    if (g !== e) n_errors++;
  endtask
  task automatic chk_ev(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) $display("BAD strobes exp %h got %h", e, g);
    if (g !== e) n_errors++;
  endtask
  task automatic chk_lvl(input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e) $display("BAD closed exp %h got %h", e, g);
    if (g !== e) n_errors++;
  endtask
  task automatic chk_irq(input logic e, input logic g);
    cmp_count++;
    if (g !== e) $display("BAD irq exp %b got %b", e, g);
    if (g !== e) n_errors++;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fail_wait("pready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic drive(input logic [3:0] nv, input logic b);
    logic [3:0] ch;
    logic [3:0] ev;
    int k;
    ch = nv ^ lvl;
    // Both-edge inputs ignore sense
    ev = ch & (MODE_V | (nv ^ SENSE_V));
    if (ch != 4'h0) ev_q.push_back({ch, ev});
    chg_acc |= ch;
    evt_acc |= ev;
    lvl = nv;
    target <= nv;
    bounce <= b;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (k < 60 || (ev_q.size() != 0 && k < 600));
    if (ev_q.size() != 0) fail_wait("strobes");
    chk_lvl(lvl ^ pol, closed);
  endtask
  always @(posedge mclk_in) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk_rd(rd_q.pop_front(), {pslverr, prdata});
    if (rst_n_in && chg !== 4'h0) begin
      if (ev_q.size() == 0) chk_ev(8'h00, {chg, evt});
      else chk_ev(ev_q.pop_front(), {chg, evt});
    end
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    rd(dipc_pkg::OFS_DBNC, 33'h0A);
    rd(dipc_pkg::OFS_MODE, 33'h0);
    rd(8'h30, 33'h100000000);
    wr(dipc_pkg::OFS_DBNC, 32'h000000C8);
    rd(dipc_pkg::OFS_DBNC, 33'h64);
    for (int i = 0; i < 4; i++) wr(dipc_pkg::OFS_CHAN_BASE + 8'(4 * i), chanw(i, 7'h64));
    wr(dipc_pkg::OFS_CHAN_BASE + 8'h04, chanw(1, 7'h00));
    rd(dipc_pkg::OFS_DBNC, 33'h01);
    rd(dipc_pkg::OFS_SENSE, 33'h06);
    drive(4'hF, 1'b0);
    drive(4'h0, 1'b1);
    repeat (12) begin
      seed = lfsr(seed);
      drive(seed[3:0], seed[4]);
    end
    rd(dipc_pkg::OFS_EVT_ST, {29'h0, evt_acc});
    rd(dipc_pkg::OFS_CHG_ST, {29'h0, chg_acc});
    wr(dipc_pkg::OFS_STATUS_POL, 32'h00000005);
    pol = 4'h5;
    wr(dipc_pkg::OFS_LEVEL, 32'h0000000F);
    rd(dipc_pkg::OFS_LEVEL, {29'h0, lvl ^ 4'h5});
    drive(~lvl, 1'b0);
    wr(dipc_pkg::OFS_EVT_MASK, 32'h0000000F);
    repeat (2) @(posedge mclk_in);
    chk_irq(|evt_acc, irq);
    wr(dipc_pkg::OFS_EVT_ST, 32'h0000000F);
    repeat (2) @(posedge mclk_in);
    chk_irq(1'b0, irq);
    wr(dipc_pkg::OFS_CHG_MASK, 32'h00000002);
    wr(dipc_pkg::OFS_CHG_ST, 32'h0000000F);
    drive(lvl ^ 4'h2, 1'b1);
    chk_irq(1'b1, irq);
    wr(dipc_pkg::OFS_CTRL, 32'h00000001);
    rd(dipc_pkg::OFS_MODE, 33'h0);
    rd(dipc_pkg::OFS_DBNC, 33'h0A);
    wrap_up();
  end
endmodule

// ==== hdl/dipc_chan.sv ====
// One conditioning path: synchroniser, debounce, polarity and edge events
`timescale 1ns/1ps
module dipc_chan (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Raw input and timing
  input wire logic raw_in,
  input wire logic tick_in,
  // Settings
  input wire logic status_inv_in,
  input wire logic both_edge_in,
  input wire logic edge_inv_in,
  input wire logic [6:0] dbnc_ms_in,
  // Conditioned results
  output logic closed_out,
  output logic change_out,
  output logic event_out
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic stable;
    logic [6:0] cnt;
    logic closed;
    logic change;
    logic event_p;
  } dipc_chan_s;

  dipc_chan_s q, d;

  always_comb begin
    d = q;
    d.sync1 = raw_in;
    d.sync2 = q.sync1;
    d.change = 1'b0;
    d.event_p = 1'b0;
    if (q.sync2 == q.stable) begin
      d.cnt = 7'h00;
    end else if (tick_in) begin
      // Tick phase is free running, so one extra tick guarantees the full time
      if (q.cnt >= dbnc_ms_in) begin
        d.stable = q.sync2;
        d.cnt = 7'h00;
        d.change = 1'b1;
        if (both_edge_in) begin
          d.event_p = 1'b1;
        end else begin
          d.event_p = q.sync2 ^ edge_inv_in;
        end
      end else begin
        d.cnt = 7'(q.cnt + 7'h01);
      end
    end
    d.closed = d.stable ^ status_inv_in;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign closed_out = q.closed;
  assign change_out = q.change;
  assign event_out = q.event_p;

endmodule

// ==== hdl/dipc_pkg.sv ====
// Shared constants of the digital input pulse conditioner
package dipc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_TIME_US;

  // ****************************************************************
  // Input count and debounce range
  // ****************************************************************
  localparam int unsigned MAX_INPUTS = 12;
  localparam int unsigned DBNC_W = 7;
  localparam logic [6:0] DBNC_MIN_MS = 7'h01;
  localparam logic [6:0] DBNC_MAX_MS = 7'h64;
  localparam logic [6:0] DBNC_RST_MS = 7'h0A;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS_POL = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_SENSE = 8'h0C;
  localparam logic [7:0] OFS_DBNC = 8'h10;
  localparam logic [7:0] OFS_LEVEL = 8'h14;
  localparam logic [7:0] OFS_EVT_ST = 8'h18;
  localparam logic [7:0] OFS_CHG_ST = 8'h1C;
  localparam logic [7:0] OFS_EVT_MASK = 8'h20;
  localparam logic [7:0] OFS_CHG_MASK = 8'h24;
  localparam logic [7:0] OFS_CHAN_BASE = 8'h40;
  localparam logic [7:0] CHAN_STRIDE = 8'h04;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CTRL_SOFT_RST_BIT = 0;
  localparam int unsigned CHAN_POL_BIT = 0;
  localparam int unsigned CHAN_MODE_BIT = 1;
  localparam int unsigned CHAN_SENSE_BIT = 2;
  localparam int unsigned CHAN_DBNC_LSB = 8;
  localparam logic RST_CFG_BIT = 1'b0;

endpackage

// ==== hdl/dipc_tick.sv ====
// Millisecond tick generator for the input conditioner
`timescale 1ns/1ps
module dipc_tick #(
  parameter int unsigned CYCLES = dipc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Tick
  output logic tick_out
);

  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } dipc_tick_s;

  dipc_tick_s q, d;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("dipc_tick needs at least two cycles per tick");
  end

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == LAST) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = CW'(q.cnt + 1'b1);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;

endmodule

// ==== hdl/dipc_top.sv ====
// Digital input pulse conditioner with APB registers and interrupt
//
// Overview of operation
// - Four, eight or twelve inputs, each with its own conditioning path.
// - Per-input status polarity; direct sense reads closed on open-to-closed.
// - Single-edge mode reports exactly one event per pulse, edge selectable.
// - Both-edge transition mode reports leading and trailing edges separately.
// - Edge sense picks open-to-closed or closed-to-open as counted edge.
// - Edge sense is ignored in both-edge transition mode.
// - New level accepted after holding for debounce time, 1 to 100 ms.
// - One debounce value shared; writing it via any input updates all.
// - Each input gives a status-change strobe and a pulse event strobe.
`timescale 1ns/1ps
module dipc_top #(
  parameter int unsigned NUM_INPUTS = 4,
  parameter int unsigned CYCLES_PER_MS = dipc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [dipc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Digital inputs
  input wire logic [NUM_INPUTS-1:0] din_in,
  // Conditioned outputs
  output logic [NUM_INPUTS-1:0] closed_out,
  output logic [NUM_INPUTS-1:0] change_strobe_out,
  output logic [NUM_INPUTS-1:0] event_strobe_out,
  // Interrupt
  output logic irq_out
);

  localparam int unsigned N = NUM_INPUTS;
  localparam logic [N-1:0] RST_VEC = {N{dipc_pkg::RST_CFG_BIT}};

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // supported input counts
  if (N != 4 && N != 8 && N != 12) begin : g_bad_inputs
    $error("dipc_top supports four, eight or twelve inputs only");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [N-1:0] status_inv;
    logic [N-1:0] both_edge;
    logic [N-1:0] edge_inv;
    logic [6:0] dbnc_ms;
    logic [N-1:0] evt_st;
    logic [N-1:0] chg_st;
    logic [N-1:0] evt_mask;
    logic [N-1:0] chg_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } dipc_top_s;

  dipc_top_s q, d;

  logic tick;
  logic [N-1:0] chan_closed;
  logic [N-1:0] chan_change;
  logic [N-1:0] chan_event;

  // ****************************************************************
  // Millisecond tick and conditioning paths
  // ****************************************************************
  // ms tick from clock
  dipc_tick #(
    .CYCLES(CYCLES_PER_MS)
  ) u_tick (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .tick_out(tick)
  );

  for (genvar g = 0; g < N; g++) begin : g_chan
    dipc_chan u_chan (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .raw_in(din_in[g]),
      .tick_in(tick),
      .status_inv_in(q.status_inv[g]),
      .both_edge_in(q.both_edge[g]),
      .edge_inv_in(q.edge_inv[g]),
      .dbnc_ms_in(q.dbnc_ms),
      .closed_out(chan_closed[g]),
      .change_out(chan_change[g]),
      .event_out(chan_event[g])
    );
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Out-of-range debounce writes saturate rather than fault
  function automatic logic [6:0] dipc_clamp(input logic [31:0] v);
    logic [6:0] r;
    r = dipc_pkg::DBNC_RST_MS;
    if (v < 32'(dipc_pkg::DBNC_MIN_MS)) begin
      r = dipc_pkg::DBNC_MIN_MS;
    end else if (v > 32'(dipc_pkg::DBNC_MAX_MS)) begin
      r = dipc_pkg::DBNC_MAX_MS;
    end else begin
      r = v[6:0];
    end
    return r;
  endfunction

  function automatic logic [31:0] dipc_zext(input logic [N-1:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[N-1:0] = v;
    return r;
  endfunction

  // ****************************************************************
  // Register decode and update
  // ****************************************************************
  logic access_first;
  logic commit;
  logic wr;
  logic hit;
  logic [31:0] rd;
  logic [N-1:0] evt_clr;
  logic [N-1:0] chg_clr;
  logic [7:0] chan_ofs;

  always_comb begin
    d = q;
    hit = 1'b0;
    rd = 32'h0000_0000;
    evt_clr = '0;
    chg_clr = '0;
    chan_ofs = 8'h00;
    access_first = psel_in & penable_in & ~q.pready;
    commit = psel_in & penable_in & q.pready;
    wr = commit & pwrite_in;

    if (paddr_in == dipc_pkg::OFS_CTRL) begin
      hit = 1'b1;
      if (wr && pwdata_in[dipc_pkg::CTRL_SOFT_RST_BIT]) begin
        d.status_inv = RST_VEC;
        d.both_edge = RST_VEC;
        d.edge_inv = RST_VEC;
        d.dbnc_ms = dipc_pkg::DBNC_RST_MS;
      end
    end else if (paddr_in == dipc_pkg::OFS_STATUS_POL) begin
      hit = 1'b1;
      rd = dipc_zext(q.status_inv);
      if (wr) begin
        d.status_inv = pwdata_in[N-1:0];
      end
    end else if (paddr_in == dipc_pkg::OFS_MODE) begin
      hit = 1'b1;
      rd = dipc_zext(q.both_edge);
      if (wr) begin
        d.both_edge = pwdata_in[N-1:0];
      end
    end else if (paddr_in == dipc_pkg::OFS_SENSE) begin
      hit = 1'b1;
      rd = dipc_zext(q.edge_inv);
      if (wr) begin
        d.edge_inv = pwdata_in[N-1:0];
      end
    end else if (paddr_in == dipc_pkg::OFS_DBNC) begin
      hit = 1'b1;
      rd[6:0] = q.dbnc_ms;
      if (wr) begin
        d.dbnc_ms = dipc_clamp(pwdata_in);
      end
    end else if (paddr_in == dipc_pkg::OFS_LEVEL) begin
      hit = 1'b1;
      rd = dipc_zext(chan_closed);
    end else if (paddr_in == dipc_pkg::OFS_EVT_ST) begin
      hit = 1'b1;
      rd = dipc_zext(q.evt_st);
      if (wr) begin
        evt_clr = pwdata_in[N-1:0];
      end
    end else if (paddr_in == dipc_pkg::OFS_CHG_ST) begin
      hit = 1'b1;
      rd = dipc_zext(q.chg_st);
      if (wr) begin
        chg_clr = pwdata_in[N-1:0];
      end
    end else if (paddr_in == dipc_pkg::OFS_EVT_MASK) begin
      hit = 1'b1;
      rd = dipc_zext(q.evt_mask);
      if (wr) begin
        d.evt_mask = pwdata_in[N-1:0];
      end
    end else if (paddr_in == dipc_pkg::OFS_CHG_MASK) begin
      hit = 1'b1;
      rd = dipc_zext(q.chg_mask);
      if (wr) begin
        d.chg_mask = pwdata_in[N-1:0];
      end
    end else begin
      // Per-input settings windows, one word per input
      for (int i = 0; i < N; i++) begin
        chan_ofs = 8'(dipc_pkg::OFS_CHAN_BASE + 8'(i) * dipc_pkg::CHAN_STRIDE);
        if (paddr_in == chan_ofs) begin
          hit = 1'b1;
          rd[dipc_pkg::CHAN_POL_BIT] = q.status_inv[i];
          rd[dipc_pkg::CHAN_MODE_BIT] = q.both_edge[i];
          rd[dipc_pkg::CHAN_SENSE_BIT] = q.edge_inv[i];
          rd[dipc_pkg::CHAN_DBNC_LSB +: dipc_pkg::DBNC_W] = q.dbnc_ms;
          if (wr) begin
            d.status_inv[i] = pwdata_in[dipc_pkg::CHAN_POL_BIT];
            d.both_edge[i] = pwdata_in[dipc_pkg::CHAN_MODE_BIT];
            d.edge_inv[i] = pwdata_in[dipc_pkg::CHAN_SENSE_BIT];
            d.dbnc_ms = dipc_clamp(32'(pwdata_in[dipc_pkg::CHAN_DBNC_LSB +:
                                                 dipc_pkg::DBNC_W]));
          end
        end
      end
    end

    // APB answer: one wait state, data and error ready with pready
    if (access_first) begin
      d.pready = 1'b1;
      d.pslverr = ~hit;
      d.prdata = (hit && !pwrite_in) ? rd : 32'h0000_0000;
    end else if (commit) begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end

    d.evt_st = (q.evt_st & ~evt_clr) | chan_event;
    d.chg_st = (q.chg_st & ~chg_clr) | chan_change;
    d.irq = |(d.evt_st & d.evt_mask) | |(d.chg_st & d.chg_mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.status_inv <= RST_VEC;
      q.both_edge <= RST_VEC;
      q.edge_inv <= RST_VEC;
      q.dbnc_ms <= dipc_pkg::DBNC_RST_MS;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign irq_out = q.irq;
  assign closed_out = chan_closed;
  assign change_strobe_out = chan_change;
  assign event_strobe_out = chan_event;

endmodule
